/* cis_core_irq_seq.v */
// Core interrupt sequencer: latching, priority, masking, vectoring and stack handling
//
// The implementer's own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ns
`include "cis_map.vh"

module cis_core_irq_seq (
  // Clock and reset
  input wire mclk,
  input wire sys_rst,
  // AXI4-Lite write address and data
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Interrupt sources
  input wire [2:0] extIrqN,
  input wire [`CIS_NUM_IRQ-1:0] intReq,
  input wire emuReq,
  input wire [1:0] bootCfgPins,
  // Pipeline status
  input wire coreRunning,
  input wire coreIdle,
  input wire [`CIS_PC_W-1:0] curPc,
  input wire [`CIS_PC_W-1:0] nextPc,
  input wire inDelayedBranch,
  input wire [`CIS_PC_W-1:0] branchTarget,
  input wire pmConflict,
  input wire vecFetchReady,
  input wire handlerInstrDone,
  input wire rtiExec,
  input wire [31:0] arithStatus,
  // Pipeline control
  output reg vecValid,
  output reg [`CIS_PC_W-1:0] vecAddr,
  output reg [`CIS_PC_W-1:0] pushedPc,
  output reg squashPipe,
  output reg retValid,
  output reg [`CIS_PC_W-1:0] retAddr,
  output reg arithRestore,
  output reg [31:0] arithRestored
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg [31:0] mode_r;
  reg [`CIS_NUM_IRQ-1:0] latch_r;
  reg [`CIS_NUM_IRQ-1:0] mask_r;
  reg [`CIS_NUM_IRQ-1:0] nestPtr_r;
  reg [2:0] edgeSel_r;
  reg [2:0] sync1_r;
  reg [2:0] sync2_r;
  reg [2:0] sync3_r;
  reg [2:0] pinLvl_r;
  reg [2:0] prevAct_r;
  reg [1:0] bootCnt_r;
  reg [1:0] state_r;
  reg [2:0] branchCnt_r;
  reg [5:0] stallIdx_r;
  reg waitFirst_r;
  reg dbHold_r;
  reg [`CIS_PC_W-1:0] dbTarget_r;
  reg [`CIS_STK_PW-1:0] pcPtr_r;
  reg [`CIS_STK_PW-1:0] stPtr_r;
  reg [`CIS_PC_W-1:0] pcStack [0:`CIS_STK_DEPTH-1];
  reg statFlag [0:`CIS_STK_DEPTH-1];
  reg [31:0] arithStack [0:`CIS_STK_DEPTH-1];
  reg [31:0] modeStack [0:`CIS_STK_DEPTH-1];
  reg [7:0] awAddr_r;
  reg [31:0] wData_r;
  reg [3:0] wStrb_r;

  // ----------------------------------------------------------------
  // External request conditioning
  // ----------------------------------------------------------------
  wire [2:0] extAct = ~pinLvl_r;
  wire [2:0] extEdge = extAct & ~prevAct_r;
  wire [2:0] extReq = (edgeSel_r & extEdge) | (~edgeSel_r & extAct);

  always @(posedge mclk) begin
    if (sys_rst) begin
      sync1_r <= 3'h7;
      sync2_r <= 3'h7;
      sync3_r <= 3'h7;
      pinLvl_r <= 3'h7;
      prevAct_r <= 3'h0;
    end else begin
      sync1_r <= extIrqN;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      // A bit changes only when the last two stages agree
      pinLvl_r <= (sync2_r & sync3_r) | (pinLvl_r & (sync2_r | sync3_r));
      prevAct_r <= extAct;
    end
  end

  // ----------------------------------------------------------------
  // Priority resolution
  // ----------------------------------------------------------------
  wire globalEn = mode_r[`CIS_MODE_GIE];
  wire nestEn = mode_r[`CIS_MODE_NEST];
  wire nestAny = |nestPtr_r;
  reg [5:0] topIdx;
  reg [`CIS_NUM_IRQ-1:0] eligible;
  reg winValid;
  reg [5:0] winIdx;
  reg [`CIS_NUM_IRQ-1:0] hwSet;
  integer i;

  always @* begin
    topIdx = 6'h00;
    for (i = `CIS_NUM_IRQ - 1; i >= 0; i = i - 1) begin
      if (nestPtr_r[i]) begin
        topIdx = i[5:0];
      end
    end
  end

  always @* begin
    eligible = {`CIS_NUM_IRQ{1'b0}};
    for (i = 0; i < `CIS_NUM_IRQ; i = i + 1) begin
      if (i[5:0] == `CIS_IDX_RESET || i[5:0] == `CIS_IDX_EMU) begin
        eligible[i] = latch_r[i];
      end else begin
        // Masked bits stay latched and compete again once unmasked
        eligible[i] = latch_r[i] & mask_r[i] & globalEn &
                      ~(nestAny & (~nestEn | (i[5:0] >= topIdx)));
      end
    end
  end

  always @* begin
    winValid = 1'b0;
    winIdx = 6'h00;
    for (i = `CIS_NUM_IRQ - 1; i >= 0; i = i - 1) begin
      if (eligible[i]) begin
        winValid = 1'b1;
        winIdx = i[5:0];
      end
    end
  end

  always @* begin
    hwSet = intReq;
    hwSet[`CIS_IDX_EMU] = intReq[`CIS_IDX_EMU] | emuReq;
    hwSet[`CIS_IDX_IRQ2] = intReq[`CIS_IDX_IRQ2] | extReq[2];
    hwSet[`CIS_IDX_IRQ1] = intReq[`CIS_IDX_IRQ1] | extReq[1];
    hwSet[`CIS_IDX_IRQ0] = intReq[`CIS_IDX_IRQ0] | extReq[0];
  end

  // ----------------------------------------------------------------
  // Entry and return decisions
  // ----------------------------------------------------------------
  wire coreAvail = coreRunning | coreIdle;
  wire idleOk = (state_r == `CIS_S_IDLE) & winValid & coreAvail & ~waitFirst_r & ~rtiExec;
  wire entryNow = idleOk & ~inDelayedBranch & ~pmConflict;
  wire entryStall = (state_r == `CIS_S_STALL);
  wire doEntry = entryNow | entryStall;
  wire [5:0] entryIdx = entryStall ? stallIdx_r : winIdx;
  wire [`CIS_PC_W-1:0] entryPc = entryStall ? nextPc : (dbHold_r ? dbTarget_r : curPc);
  wire entryIsReset = (entryIdx == `CIS_IDX_RESET);
  wire entryStat = (entryIdx == `CIS_IDX_IRQ2) | (entryIdx == `CIS_IDX_IRQ1) |
                   (entryIdx == `CIS_IDX_IRQ0) | (entryIdx == `CIS_IDX_TMR_HI) |
                   (entryIdx == `CIS_IDX_TMR_LO);
  wire doPush = doEntry & ~entryIsReset & (pcPtr_r != `CIS_STK_DEPTH);
  wire doStatPush = doPush & entryStat & (stPtr_r != `CIS_STK_DEPTH);
  wire doRet = rtiExec & (state_r == `CIS_S_IDLE) & (pcPtr_r != {`CIS_STK_PW{1'b0}});
  wire [`CIS_STK_PW-1:0] pcTop = pcPtr_r - 1'b1;
  wire [`CIS_STK_PW-1:0] stTop = stPtr_r - 1'b1;
  wire popStat = doRet & statFlag[pcTop[2:0]] & (stPtr_r != {`CIS_STK_PW{1'b0}});
  wire [7:0] vecOff = {entryIdx, 2'b00};

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    if (sys_rst) begin
      state_r <= `CIS_S_IDLE;
      branchCnt_r <= 3'h0;
      stallIdx_r <= 6'h00;
      waitFirst_r <= 1'b0;
      dbHold_r <= 1'b0;
      dbTarget_r <= {`CIS_PC_W{1'b0}};
      pcPtr_r <= {`CIS_STK_PW{1'b0}};
      stPtr_r <= {`CIS_STK_PW{1'b0}};
      vecValid <= 1'b0;
      vecAddr <= {`CIS_PC_W{1'b0}};
      pushedPc <= {`CIS_PC_W{1'b0}};
      squashPipe <= 1'b0;
      retValid <= 1'b0;
      retAddr <= {`CIS_PC_W{1'b0}};
      arithRestore <= 1'b0;
      arithRestored <= 32'h00000000;
    end else begin
      vecValid <= 1'b0;
      retValid <= 1'b0;
      arithRestore <= 1'b0;
      // Remember the branch target while a delayed branch shields a request
      if (doEntry) begin
        dbHold_r <= 1'b0;
      end else if (inDelayedBranch & winValid) begin
        dbHold_r <= 1'b1;
        dbTarget_r <= branchTarget;
      end else if (~winValid) begin
        dbHold_r <= 1'b0;
      end
      if (handlerInstrDone) begin
        waitFirst_r <= 1'b0;
      end
      case (state_r)
        `CIS_S_IDLE: begin
          if (idleOk & ~inDelayedBranch & pmConflict) begin
            state_r <= `CIS_S_STALL;
            stallIdx_r <= winIdx;
          end
        end
        `CIS_S_STALL: begin
          state_r <= `CIS_S_IDLE;
        end
        `CIS_S_BRANCH: begin
          if (vecFetchReady) begin
            branchCnt_r <= branchCnt_r + 3'h1;
            if (branchCnt_r == `CIS_BRANCH_CYC - 1) begin
              state_r <= `CIS_S_IDLE;
              squashPipe <= 1'b0;
              branchCnt_r <= 3'h0;
            end
          end
        end
        default: begin
          state_r <= `CIS_S_IDLE;
        end
      endcase
      if (doEntry) begin
        state_r <= `CIS_S_BRANCH;
        branchCnt_r <= 3'h0;
        squashPipe <= 1'b1;
        vecValid <= 1'b1;
        vecAddr <= `CIS_VEC_BASE + {{(`CIS_PC_W - 8){1'b0}}, vecOff};
        pushedPc <= entryPc;
        waitFirst_r <= nestEn & ~entryIsReset;
      end
      if (doPush) begin
        pcStack[pcPtr_r[2:0]] <= entryPc;
        statFlag[pcPtr_r[2:0]] <= doStatPush;
        pcPtr_r <= pcPtr_r + 1'b1;
      end
      if (doStatPush) begin
        arithStack[stPtr_r[2:0]] <= arithStatus;
        modeStack[stPtr_r[2:0]] <= mode_r;
        stPtr_r <= stPtr_r + 1'b1;
      end
      if (doRet) begin
        retValid <= 1'b1;
        retAddr <= pcStack[pcTop[2:0]];
        pcPtr_r <= pcTop;
      end
      if (popStat) begin
        arithRestore <= 1'b1;
        arithRestored <= arithStack[stTop[2:0]];
        stPtr_r <= stTop;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  wire wrFire = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  wire wrHit = (awAddr_r[7:5] == 3'h0) & (awAddr_r[1:0] == 2'h0);
  wire [31:0] strbMask = {{8{wStrb_r[3]}}, {8{wStrb_r[2]}}, {8{wStrb_r[1]}}, {8{wStrb_r[0]}}};
  wire wrMode = wrFire & (awAddr_r == `CIS_OFF_MODE);
  wire wrLatch = wrFire & (awAddr_r == `CIS_OFF_LATCH);
  wire wrMask = wrFire & (awAddr_r == `CIS_OFF_MASK);
  wire wrExt = wrFire & (awAddr_r == `CIS_OFF_EXTLM);
  wire wrExtCtl = wrFire & (awAddr_r == `CIS_OFF_EXTCTL);
  wire [31:0] extLm = {6'h00, mask_r[41:32], 6'h00, latch_r[41:32]};
  wire [31:0] extLmNew = (extLm & ~strbMask) | (wData_r & strbMask);
  wire [31:0] latchNew = (latch_r[31:0] & ~strbMask) | (wData_r & strbMask);
  wire [31:0] maskNew = (mask_r[31:0] & ~strbMask) | (wData_r & strbMask);
  wire [31:0] modeNew = (mode_r & ~strbMask) | (wData_r & strbMask);
  reg [31:0] rdMux;
  reg rdOk;
  reg [`CIS_NUM_IRQ-1:0] latch_nxt;
  reg [`CIS_NUM_IRQ-1:0] entryBit;

  always @* begin
    rdOk = 1'b1;
    case (s_axi_araddr)
      `CIS_OFF_MODE: rdMux = mode_r;
      `CIS_OFF_LATCH: rdMux = latch_r[31:0];
      `CIS_OFF_MASK: rdMux = mask_r[31:0];
      `CIS_OFF_EXTLM: rdMux = extLm;
      `CIS_OFF_NPTR_LO: rdMux = nestPtr_r[31:0];
      `CIS_OFF_NPTR_HI: rdMux = {22'h000000, nestPtr_r[41:32]};
      `CIS_OFF_EXTCTL: rdMux = {29'h00000000, edgeSel_r};
      `CIS_OFF_STATUS: rdMux = {14'h0000, winIdx, winValid, waitFirst_r, state_r, stPtr_r, pcPtr_r};
      default: begin
        rdMux = 32'h00000000;
        rdOk = 1'b0;
      end
    endcase
  end

  always @* begin
    entryBit = {`CIS_NUM_IRQ{1'b0}};
    entryBit[entryIdx] = doEntry;
    latch_nxt = latch_r;
    if (wrLatch) begin
      // Reset and emulator bits cannot be touched by software
      latch_nxt[31:2] = latchNew[31:2];
    end
    if (wrExt) begin
      latch_nxt[41:32] = extLmNew[`CIS_EXT_LATCH_LSB +: `CIS_EXT_W];
    end
    latch_nxt = latch_nxt | hwSet;
    // Serviced bits are cleared even against a new set: the handler owns them
    latch_nxt = latch_nxt & ~entryBit & ~nestPtr_r;
  end

  always @(posedge mclk) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h00000000;
      awAddr_r <= 8'h00;
      wData_r <= 32'h00000000;
      wStrb_r <= 4'h0;
      mode_r <= `CIS_MODE_RST;
      latch_r <= {{(`CIS_NUM_IRQ - 1){1'b0}}, 1'b1};
      mask_r <= {`CIS_NUM_IRQ{1'b0}};
      nestPtr_r <= {`CIS_NUM_IRQ{1'b0}};
      edgeSel_r <= 3'h0;
      bootCnt_r <= 2'h0;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        awAddr_r <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wrFire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrHit ? 2'h0 : 2'h2;
      end
      if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdMux;
        s_axi_rresp <= rdOk ? 2'h0 : 2'h2;
      end
      if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
      latch_r <= latch_nxt;
      if (wrMode) begin
        mode_r <= modeNew;
      end
      if (popStat) begin
        mode_r <= modeStack[stTop[2:0]];
      end
      if (wrMask) begin
        mask_r[31:0] <= maskNew;
      end
      if (wrExt) begin
        mask_r[41:32] <= extLmNew[`CIS_EXT_MASK_LSB +: `CIS_EXT_W];
      end
      if (wrExtCtl) begin
        edgeSel_r <= wData_r[2:0] & strbMask[2:0];
      end
      // Boot straps pass the pin synchroniser depth before they are trusted
      if (bootCnt_r != `CIS_BOOT_SETTLE) begin
        bootCnt_r <= bootCnt_r + 2'h1;
        if (bootCnt_r == `CIS_BOOT_SETTLE - 2'h1) begin
          mask_r[`CIS_IDX_BOOT + {4'h0, bootCfgPins}] <= 1'b1;
        end
      end
      // Return clears the innermost level before a new entry may set one
      if (doRet) begin
        nestPtr_r[topIdx] <= 1'b0;
      end
      if (doEntry & ~entryIsReset) begin
        nestPtr_r[entryIdx] <= 1'b1;
      end
    end
  end

endmodule // cis_core_irq_seq

/* cis_core_irq_seq_test.sv */
// Self-checking testbench for the core interrupt sequencer
`timescale 1ns/1ns
`include "cis_map.vh"
`define CHK(a, b) begin nChecks++; if ((a) !== (b)) begin badCount++; $display("BAD t=%0t got %h exp %h", $time, (a), (b)); end end

module cis_core_irq_seq_test;
  localparam [`CIS_PC_W-1:0] TGT = 24'h000500;
  localparam int EXT_LAT = 5;
  logic mclk = 1'b0, sys_rst = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [2:0] extIrqN = 3'h7;
  logic [`CIS_NUM_IRQ-1:0] intReq = '0;
  logic dbReq = 1'b0, pmReq = 1'b0, haltReq = 1'b0, rtiReq = 1'b0, slow = 1'b0, emuReq = 1'b0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata, arithStatus, arithRestored;
  wire coreRunning, coreIdle, inDelayedBranch, pmConflict, vecFetchReady, handlerInstrDone, rtiExec;
  wire vecValid, squashPipe, retValid, arithRestore;
  wire [`CIS_PC_W-1:0] curPc, nextPc, branchTarget, vecAddr, pushedPc, retAddr;
  int badCount = 0, nChecks = 0, cyc = 0, vecCnt = 0, retCnt = 0, expV = 0, expR = 0, dCyc = 0, vCyc = 0;
  logic [`CIS_PC_W-1:0] vAddr, vPush, vCur, rAddr, p0;
  logic [31:0] rData, rd;
  logic [1:0] rsp, bRsp;
  logic vHd, rRest, hd = 1'b0;

  always #20 mclk = ~mclk;

  cis_core_irq_seq dut (.mclk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .extIrqN, .intReq, .emuReq, .bootCfgPins(2'h1), .coreRunning, .coreIdle, .curPc, .nextPc,
    .inDelayedBranch, .branchTarget, .pmConflict, .vecFetchReady, .handlerInstrDone, .rtiExec,
    .arithStatus, .vecValid, .vecAddr, .pushedPc, .squashPipe, .retValid, .retAddr, .arithRestore,
    .arithRestored);

  cis_pipe_model #(.TGT(TGT)) model (.mclk, .sys_rst, .dbReq, .pmReq, .haltReq, .rtiReq, .slow, .vecValid,
    .curPc, .nextPc, .branchTarget, .inDelayedBranch, .coreRunning, .coreIdle, .arithStatus, .pmConflict,
    .vecFetchReady, .handlerInstrDone, .rtiExec);

  // --------------------------------
  // Observation and bus tasks
  // --------------------------------
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (handlerInstrDone) hd <= 1'b1;
    if (vecValid) begin
      vecCnt <= vecCnt + 1;
      vAddr <= vecAddr;
      vPush <= pushedPc;
      vCur <= curPc;
      vCyc <= cyc;
      vHd <= hd;
      hd <= 1'b0;
    end
    if (retValid) begin
      retCnt <= retCnt + 1;
      rAddr <= retAddr;
      rRest <= arithRestore;
      rData <= arithRestored;
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", nChecks, badCount);
    if (badCount == 0 && nChecks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic tmo();
    badCount++;
    $display("BAD t=%0t got %h exp %h", $time, 1'b0, 1'b1);
    results();
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic axW(input [7:0] a, input [31:0] d);
    int i;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    bRsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (i == 50) tmo();
  endtask

  task automatic axR(input [7:0] a, output [31:0] d, output [1:0] r);
    int i;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (i == 50) tmo();
  endtask

  task automatic rdChk(input [7:0] a, input [31:0] e);
    axR(a, rd, rsp);
    `CHK(rd, e)
    `CHK(rsp, 2'h0)
  endtask

  // Aux bits raise halt, conflict or delayed branch together with the request
  task automatic pulse(input [`CIS_NUM_IRQ-1:0] m, input [2:0] aux);
    @(posedge mclk);
    intReq <= m;
    {haltReq, pmReq, dbReq} <= aux;
    dCyc = cyc;
    @(posedge mclk);
    intReq <= '0;
    {haltReq, pmReq, dbReq} <= 3'h0;
  endtask

  task automatic getV();
    int i;
    expV++;
    for (i = 0; i < 60 && vecCnt != expV; i++) @(posedge mclk);
    if (vecCnt != expV) tmo();
  endtask

  task automatic rti();
    int i;
    @(posedge mclk);
    // A return is only executed once the vector branch cycles are over
    for (i = 0; i < 60 && squashPipe; i++) @(posedge mclk);
    rtiReq <= 1'b1;
    @(posedge mclk);
    rtiReq <= 1'b0;
    expR++;
    for (i = 0; i < 60 && retCnt != expR; i++) @(posedge mclk);
    if (retCnt != expR) tmo();
  endtask

  // --------------------------------
  // Scenarios
  // --------------------------------
  initial begin
    int k;
    tick(6);
    sys_rst <= 1'b0;
    getV();
    `CHK(vAddr, 24'h0)
    rdChk(`CIS_OFF_MODE, 32'h0);
    rdChk(`CIS_OFF_MASK, 32'h00200000);
    rdChk(`CIS_OFF_LATCH, 32'h0);
    axR(8'h40, rd, rsp);
    `CHK(rsp, 2'h2)
    axW(8'h40, 32'hffffffff);
    `CHK(bRsp, 2'h2)
    $display("end reset");
    axW(`CIS_OFF_MASK, 32'h200);
    `CHK(bRsp, 2'h0)
    pulse(42'h200, 3'h0);
    tick(8);
    `CHK(vecCnt, expV)
    @(posedge mclk);
    emuReq <= 1'b1;
    @(posedge mclk);
    emuReq <= 1'b0;
    getV();
    `CHK(vAddr, 24'h04)
    rti();
    `CHK(rAddr, vPush)
    axW(`CIS_OFF_MASK, 32'h0);
    axW(`CIS_OFF_MODE, 32'h1);
    tick(8);
    `CHK(vecCnt, expV)
    rdChk(`CIS_OFF_LATCH, 32'h200);
    axW(`CIS_OFF_MASK, 32'h200);
    getV();
    `CHK(vAddr, 24'h24)
    `CHK(vPush, vCur - 24'h1)
    pulse(42'h200, 3'h0);
    rdChk(`CIS_OFF_LATCH, 32'h0);
    rti();
    `CHK(rAddr, vPush)
    `CHK(rRest, 1'b0)
    tick(8);
    `CHK(vecCnt, expV)
    $display("end enable and mask");
    axW(`CIS_OFF_MASK, 32'h1200);
    pulse(42'h1200, 3'h0);
    getV();
    `CHK(vAddr, 24'h24)
    `CHK(vCyc - dCyc, 3)
    tick(10);
    `CHK(vecCnt, expV)
    rti();
    getV();
    `CHK(vAddr, 24'h30)
    rti();
    $display("end priority");
    axW(`CIS_OFF_MODE, 32'h3);
    pulse(42'h1000, 3'h0);
    getV();
    p0 = vPush;
    pulse(42'h200, 3'h0);
    getV();
    `CHK(vAddr, 24'h24)
    `CHK(vHd, 1'b1)
    rdChk(`CIS_OFF_NPTR_LO, 32'h1200);
    rti();
    `CHK(rAddr, vPush)
    rti();
    `CHK(rAddr, p0)
    axW(`CIS_OFF_MODE, 32'h1);
    $display("end nesting");
    pulse(42'h200, 3'h1);
    getV();
    `CHK(vPush, TGT)
    rti();
    pulse(42'h200, 3'h2);
    getV();
    `CHK(vPush, vCur + 24'h1)
    rti();
    pulse(42'h200, 3'h4);
    tick(4);
    `CHK(vecCnt, expV)
    getV();
    `CHK(vAddr, 24'h24)
    rti();
    $display("end branch stall halt");
    axW(`CIS_OFF_MASK, 32'h8);
    slow <= 1'b1;
    pulse(42'h8, 3'h0);
    getV();
    `CHK(vAddr, 24'h0c)
    rti();
    `CHK(rRest, 1'b1)
    `CHK(rData, {8'ha5, vPush})
    slow <= 1'b0;
    $display("end timer");
    axW(`CIS_OFF_EXTCTL, 32'h7);
    axW(`CIS_OFF_MASK, 32'h70);
    for (k = 0; k < 3; k++) begin
      @(posedge mclk);
      extIrqN[k] <= 1'b0;
      dCyc = cyc;
      getV();
      `CHK(vAddr, 24'(24 - 4 * k))
      `CHK(vCyc - dCyc, EXT_LAT + 2)
      rti();
      `CHK(rRest, 1'b1)
      tick(10);
      `CHK(vecCnt, expV)
      extIrqN[k] <= 1'b1;
    end
    // Let the last released pin settle before level mode is chosen
    tick(6);
    axW(`CIS_OFF_EXTCTL, 32'h0);
    @(posedge mclk);
    extIrqN[0] <= 1'b0;
    getV();
    `CHK(vAddr, 24'h18)
    rti();
    getV();
    `CHK(vAddr, 24'h18)
    extIrqN[0] <= 1'b1;
    tick(8);
    rti();
    tick(10);
    `CHK(vecCnt, expV)
    $display("end external");
    results();
  end
endmodule // cis_core_irq_seq_test

/* cis_map.vh */
// Address map, field positions, reset values and timing counts of the core interrupt sequencer
`ifndef CIS_MAP_VH
`define CIS_MAP_VH

// Register byte offsets
`define CIS_OFF_MODE     8'h00
`define CIS_OFF_LATCH    8'h04
`define CIS_OFF_MASK     8'h08
`define CIS_OFF_EXTLM    8'h0c
`define CIS_OFF_NPTR_LO  8'h10
`define CIS_OFF_NPTR_HI  8'h14
`define CIS_OFF_EXTCTL   8'h18
`define CIS_OFF_STATUS   8'h1c

// Mode control fields
`define CIS_MODE_GIE     0
`define CIS_MODE_NEST    1
`define CIS_MODE_RST     32'h00000000

// Extended latch/mask layout
`define CIS_EXT_LATCH_LSB 0
`define CIS_EXT_MASK_LSB  16
`define CIS_EXT_W         10

// Interrupt indices, 0 highest priority
`define CIS_NUM_IRQ      42
`define CIS_IDX_RESET    6'h00
`define CIS_IDX_EMU      6'h01
`define CIS_IDX_TMR_HI   6'h03
`define CIS_IDX_IRQ2     6'h04
`define CIS_IDX_IRQ1     6'h05
`define CIS_IDX_IRQ0     6'h06
`define CIS_IDX_BOOT     6'h14
`define CIS_IDX_TMR_LO   6'h1f

// Program addresses and vector table
`define CIS_PC_W         24
`define CIS_VEC_BASE     24'h000000
`define CIS_VEC_SHIFT    2

// Stacks
`define CIS_STK_DEPTH    8
`define CIS_STK_PW       4

// Timing
`define CIS_CLK_MHZ      25
`define CIS_BRANCH_INSTR 4
`define CIS_BRANCH_CYC   (`CIS_BRANCH_INSTR)
`define CIS_BOOT_SETTLE  2'h3

// Sequencer states
`define CIS_S_IDLE       2'h0
`define CIS_S_STALL      2'h1
`define CIS_S_BRANCH     2'h2

`endif

/* cis_pipe_model.sv */
// Behavioural pipeline and core-status model facing the sequencer
`timescale 1ns/1ns
`include "cis_map.vh"

module cis_pipe_model #(
  parameter [`CIS_PC_W-1:0] TGT = 24'h000500
) (
  // Clock and reset
  input wire mclk,
  input wire sys_rst,
  // Requests from the bench, and the vector strobe from the sequencer
  input wire dbReq,
  input wire pmReq,
  input wire haltReq,
  input wire rtiReq,
  input wire slow,
  input wire vecValid,
  // Pipeline status
  output reg [`CIS_PC_W-1:0] curPc,
  output wire [`CIS_PC_W-1:0] nextPc,
  output wire [`CIS_PC_W-1:0] branchTarget,
  output wire inDelayedBranch,
  output wire coreRunning,
  output wire coreIdle,
  output wire [31:0] arithStatus,
  output reg pmConflict,
  output reg vecFetchReady,
  output reg handlerInstrDone,
  output reg rtiExec
);
  reg [2:0] dbCnt;
  reg [2:0] haltCnt;
  reg [2:0] hdCnt;
  reg stall;
  reg idleMode;

  assign nextPc = curPc + 24'h1;
  // Outside a branch the target lines carry junk, never a stale target
  assign branchTarget = inDelayedBranch ? TGT : ~TGT;
  assign inDelayedBranch = dbCnt != 3'h0;
  assign coreRunning = haltCnt == 3'h0 && !idleMode;
  assign coreIdle = idleMode;
  assign arithStatus = {8'ha5, curPc};

  always @(posedge mclk) begin
    if (sys_rst) begin
      curPc <= 24'h000100;
      dbCnt <= 3'h0;
      haltCnt <= 3'h0;
      hdCnt <= 3'h0;
      stall <= 1'b0;
      idleMode <= 1'b0;
      pmConflict <= 1'b0;
      vecFetchReady <= 1'b1;
      handlerInstrDone <= 1'b0;
      rtiExec <= 1'b0;
    end else begin
      // A stalled pipeline does not advance its program counter
      curPc <= (pmConflict || stall) ? curPc : nextPc;
      stall <= pmConflict;
      pmConflict <= pmReq;
      dbCnt <= dbReq ? 3'h3 : dbCnt - {2'h0, |dbCnt};
      haltCnt <= haltReq ? 3'h6 : haltCnt - {2'h0, |haltCnt};
      idleMode <= (haltCnt == 3'h1) || (idleMode && !vecValid);
      // Slow mode stands in for a vector fetch over the external port
      vecFetchReady <= slow ? !vecFetchReady : 1'b1;
      hdCnt <= vecValid ? 3'h6 : hdCnt - {2'h0, |hdCnt};
      handlerInstrDone <= hdCnt == 3'h1;
      rtiExec <= rtiReq;
    end
  end
endmodule // cis_pipe_model

/* cis_seq_monitor.sv */
// Concurrent port checks for the core interrupt sequencer
`timescale 1ns/1ns
`include "cis_map.vh"

module cis_seq_monitor (
  // Clock and reset
  input wire mclk,
  input wire sys_rst,
  // Pipeline status
  input wire coreRunning,
  input wire coreIdle,
  input wire inDelayedBranch,
  input wire pmConflict,
  input wire rtiExec,
  // Pipeline control
  input wire vecValid,
  input wire [`CIS_PC_W-1:0] vecAddr,
  input wire squashPipe,
  input wire retValid,
  input wire arithRestore
);
  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  // --------------------------------
  // Entry and return
  // --------------------------------
  a_no_reentry: assert property (vecValid |=> !vecValid [*4]) else $error("entry inside branch cycles");
  a_squash_hold: assert property (vecValid |=> squashPipe [*3]) else $error("squash ended early");
  a_vec_aligned: assert property (vecValid |-> vecAddr[1:0] == 2'h0 && vecAddr < 24'h0000a8) else $error("bad vector");
  a_no_vec_stopped: assert property (!(coreRunning || coreIdle) |=> !vecValid) else $error("entry while stopped");
  a_no_vec_branch: assert property (inDelayedBranch |=> !vecValid) else $error("entry inside delayed branch");
  a_no_vec_conflict: assert property (pmConflict |=> !vecValid) else $error("entry during stall");
  a_ret_after_rti: assert property (retValid |-> $past(rtiExec)) else $error("return without rti");
  a_no_vec_rti: assert property (rtiExec |=> !vecValid) else $error("entry on return");
  a_restore_with_ret: assert property (arithRestore |-> retValid) else $error("status pop alone");
endmodule // cis_seq_monitor

bind cis_core_irq_seq cis_seq_monitor uMon (.mclk, .sys_rst, .coreRunning, .coreIdle, .inDelayedBranch,
  .pmConflict, .rtiExec, .vecValid, .vecAddr, .squashPipe, .retValid, .arithRestore);
